// ===== rtl/memlink_err_pkg.sv
// constants for the memory-expansion link error-signal routing block
package memlink_err_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 12;
  localparam int unsigned FLAG_W = 15;
  localparam int unsigned EN_W   = 16;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] ERR0_EN_INDEX = 12'h0e0;
  localparam logic [IDX_W-1:0] ERR1_EN_INDEX = 12'h0e2;
  localparam logic [IDX_W-1:0] IRQ_STAT_INDEX = 12'h0e8;
  localparam logic [IDX_W-1:0] IRQ_MASK_INDEX = 12'h0e9;
  localparam logic [IDX_W-1:0] FLAG_VIEW_INDEX = 12'h0ea;

  // ==========================================================
  // reset values and writable fields
  localparam logic [EN_W-1:0] ENABLE_RESET = 16'h0000;
  localparam logic [EN_W-1:0] ENABLE_WRITABLE = 16'h7fff;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ==========================================================
  // error flag / enable bit positions
  localparam int unsigned BIT_FATAL_REMOTE      = 14;
  localparam int unsigned BIT_LAST_RETRY_A      = 13;
  localparam int unsigned BIT_UNCORR_REMOTE     = 12;
  localparam int unsigned BIT_CORR_REMOTE       = 11;
  localparam int unsigned BIT_POISON_CFG_WRITE  = 10;
  localparam int unsigned BIT_LAST_RETRY_B      = 9;
  localparam int unsigned BIT_POSTED_FAILED     = 8;
  localparam int unsigned BIT_HOTPLUG_BUS       = 7;
  localparam int unsigned BIT_LINK_ABORT        = 6;
  localparam int unsigned BIT_LINK_CTRL_ERR     = 5;
  localparam int unsigned BIT_POISON_MEM_WRITE  = 4;
  localparam int unsigned BIT_INBOUND_CRC       = 3;
  localparam int unsigned BIT_FIRST_REQ_TIMEOUT = 2;
  localparam int unsigned BIT_INBOUND_CORR_ECC  = 1;
  localparam int unsigned BIT_INBOUND_UNCORR_ECC = 0;

  // ==========================================================
  // interrupt status bits
  localparam int unsigned IRQ_OUT0_RISE = 0;
  localparam int unsigned IRQ_OUT1_RISE = 1;

endpackage

// ===== rtl/memlink_error_signal_routing.sv
// error-signal routing for one memory-expansion link port, APB slave
//
// Behaviour
// R1: error out 0 high when a flag is set and its out-0 enable bit is set.
// R2: error out 1 likewise from the out-1 enables; bit 15 reserved, all reset to 0.
// R3: software should enable one output at most per error condition.
// R4: bit 14 routes a fatal error reported by the memory bridge.
// R5: bits 13 and 9 both route the failed-on-final-retry condition.
// R6: bit 12 routes an uncorrectable error reported by the memory bridge.
// R7: bit 11 routes a correctable-error indication from the memory bridge.
// R8: bit 10 routes sending a poisoned configuration write to the bridge.
// R9: bit 8 routes requests posted to a failed link.
// R10: bit 7 routes a hot-plug error on the regulator management bus.
// R11: bit 6 routes an abort of the inbound link.
// R12: bit 5 routes inbound link-layer control errors.
// R13: bit 4 routes the poisoned memory-write event.
// R14: bit 3 routes an inbound CRC error.
// R15: bit 2 routes a first-request time-out.
// R16: bits 1 and 0 route inbound correctable and first uncorrectable ECC errors.
// R17: each output is OR of enabled flags over bits 14..0; bit 15 never counts.
// R18: enable bits survive warm reset and clear only on power-good reset.
`timescale 1ns/1ps
`default_nettype none

module memlink_error_signal_routing (
  // clock and resets
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   warm_rst_n,
  // apb slave
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [memlink_err_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [memlink_err_pkg::DATA_W-1:0]     pwdata,
  input  wire logic [3:0]                             pstrb,
  output var  logic [memlink_err_pkg::DATA_W-1:0]     prdata,
  output logic                                        pready,
  output var  logic                                   pslverr,
  // error flags from the link error detection logic
  input  wire logic [memlink_err_pkg::FLAG_W-1:0]     link_err_flags,
  // routed error outputs and interrupt
  output var  logic                                   err_out0,
  output var  logic                                   err_out1,
  output logic                                        irq
);
  import memlink_err_pkg::*;

  // ==========================================================
  // routing function
  // last-retry shows on either flag 13 or 9, and either enable routes it
  function automatic logic route(input logic [FLAG_W-1:0] f,
                                 input logic [EN_W-1:0]   e);
    logic [FLAG_W-1:0] hit;
    hit = '0;
    hit[BIT_FATAL_REMOTE]       = f[BIT_FATAL_REMOTE] & e[BIT_FATAL_REMOTE]; // R4
    hit[BIT_LAST_RETRY_A]       = (f[BIT_LAST_RETRY_A] | f[BIT_LAST_RETRY_B])
                                & (e[BIT_LAST_RETRY_A] | e[BIT_LAST_RETRY_B]); // R5
    hit[BIT_UNCORR_REMOTE]      = f[BIT_UNCORR_REMOTE] & e[BIT_UNCORR_REMOTE]; // R6
    hit[BIT_CORR_REMOTE]        = f[BIT_CORR_REMOTE] & e[BIT_CORR_REMOTE]; // R7
    hit[BIT_POISON_CFG_WRITE]   = f[BIT_POISON_CFG_WRITE] & e[BIT_POISON_CFG_WRITE]; // R8
    hit[BIT_POSTED_FAILED]      = f[BIT_POSTED_FAILED] & e[BIT_POSTED_FAILED]; // R9
    hit[BIT_HOTPLUG_BUS]        = f[BIT_HOTPLUG_BUS] & e[BIT_HOTPLUG_BUS]; // R10
    hit[BIT_LINK_ABORT]         = f[BIT_LINK_ABORT] & e[BIT_LINK_ABORT]; // R11
    hit[BIT_LINK_CTRL_ERR]      = f[BIT_LINK_CTRL_ERR] & e[BIT_LINK_CTRL_ERR]; // R12
    hit[BIT_POISON_MEM_WRITE]   = f[BIT_POISON_MEM_WRITE] & e[BIT_POISON_MEM_WRITE]; // R13
    hit[BIT_INBOUND_CRC]        = f[BIT_INBOUND_CRC] & e[BIT_INBOUND_CRC]; // R14
    hit[BIT_FIRST_REQ_TIMEOUT]  = f[BIT_FIRST_REQ_TIMEOUT] & e[BIT_FIRST_REQ_TIMEOUT]; // R15
    hit[BIT_INBOUND_CORR_ECC]   = f[BIT_INBOUND_CORR_ECC] & e[BIT_INBOUND_CORR_ECC]; // R16
    hit[BIT_INBOUND_UNCORR_ECC] = f[BIT_INBOUND_UNCORR_ECC]
                                & e[BIT_INBOUND_UNCORR_ECC]; // R16
    return |hit; // R17
  endfunction

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [EN_W-1:0] merge(input logic [EN_W-1:0]   old,
                                            input logic [DATA_W-1:0] wd,
                                            input logic [3:0]        st);
    logic [EN_W-1:0] v;
    v = old;
    if (st[0]) begin
      v[7:0] = wd[7:0];
    end
    if (st[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  // ==========================================================
  // state
  logic [EN_W-1:0]   en0_reg;
  logic [EN_W-1:0]   en1_reg;
  logic [1:0]        stat_reg;
  logic [1:0]        stat_next;
  logic [1:0]        mask_reg;
  logic              route0;
  logic              route1;
  logic [1:0]        rise;
  logic              setup;
  logic              wr;
  logic [IDX_W-1:0]  idx;
  logic              mapped;
  logic [DATA_W-1:0] rd_mux;

  // ==========================================================
  // bus decode
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign idx = paddr[ADDR_W-1:2];
  assign pready = 1'b1; // every access completes in its first access cycle

  // decode of mapped indices and read mux
  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    case (idx)
      ERR0_EN_INDEX: begin
        rd_mux[EN_W-1:0] = en0_reg;
      end
      ERR1_EN_INDEX: begin
        rd_mux[EN_W-1:0] = en1_reg;
      end
      IRQ_STAT_INDEX: begin
        rd_mux[1:0] = stat_reg;
      end
      IRQ_MASK_INDEX: begin
        rd_mux[1:0] = mask_reg;
      end
      FLAG_VIEW_INDEX: begin
        rd_mux[FLAG_W-1:0] = link_err_flags;
        rd_mux[16] = err_out0;
        rd_mux[17] = err_out1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // read data and error answer are caught in the setup cycle so they come
  // from flip-flops; the trade is that a read shows state one cycle old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? '0 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  // ==========================================================
  // routing enables: sticky, so only the power-good reset clears them;
  // reserved bit 15 is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en0_reg <= ENABLE_RESET; // R18
      en1_reg <= ENABLE_RESET; // R18
    end else if (wr) begin
      if (idx == ERR0_EN_INDEX) begin
        en0_reg <= merge(en0_reg, pwdata, pstrb) & ENABLE_WRITABLE; // R1
      end
      if (idx == ERR1_EN_INDEX) begin
        en1_reg <= merge(en1_reg, pwdata, pstrb) & ENABLE_WRITABLE; // R2
      end
    end
  end

  // ==========================================================
  // routed outputs; no check that one error drives one output only,
  // software owns that choice
  assign route0 = route(link_err_flags, en0_reg); // R1
  assign route1 = route(link_err_flags, en1_reg); // R2

  // outputs registered: one cycle from flag to pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_out0 <= 1'b0;
      err_out1 <= 1'b0;
    end else if (!warm_rst_n) begin
      err_out0 <= 1'b0;
      err_out1 <= 1'b0;
    end else begin
      err_out0 <= route0; // R1
      err_out1 <= route1; // R2
    end
  end

  // ==========================================================
  // interrupt: rising edge of each output sets a sticky status bit
  assign rise = {route1 & ~err_out1, route0 & ~err_out0};

  // write-one-to-clear; a new rise in the same cycle wins over the clear
  always_comb begin
    stat_next = stat_reg;
    if (wr && idx == IRQ_STAT_INDEX && pstrb[0]) begin
      stat_next = stat_reg & ~pwdata[1:0];
    end
    stat_next = stat_next | rise;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= IRQ_RESET;
    end else if (!warm_rst_n) begin
      stat_reg <= IRQ_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // mask bit 1 lets the status bit through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= IRQ_RESET;
    end else if (!warm_rst_n) begin
      mask_reg <= IRQ_RESET;
    end else if (wr && idx == IRQ_MASK_INDEX && pstrb[0]) begin
      mask_reg <= pwdata[1:0];
    end
  end

  assign irq = |(stat_reg & mask_reg);

  // ==========================================================
  // assertions
  AST_OUT0_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn) // R1
    warm_rst_n |=> (err_out0 == $past(route0)))
    else $error("error out 0 does not follow its routed flags");

  AST_OUT1_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn) // R2
    warm_rst_n |=> (err_out1 == $past(route1)))
    else $error("error out 1 does not follow its routed flags");

  AST_NO_ROUTE_UNENABLED: assert property (@(posedge pclk) disable iff (!presetn) // R17
    (en0_reg == '0) && (en1_reg == '0) |=> !err_out0 && !err_out1)
    else $error("an output rose with no enable bit set");

  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R2
    !en0_reg[15] && !en1_reg[15])
    else $error("reserved enable bit 15 holds a one");

  AST_FATAL_OUT1: assert property (@(posedge pclk) disable iff (!presetn) // R4
    warm_rst_n && link_err_flags[BIT_FATAL_REMOTE] && en1_reg[BIT_FATAL_REMOTE]
    |=> err_out1)
    else $error("fatal remote error not routed to out 1");

  AST_LAST_RETRY_CROSS: assert property (@(posedge pclk) disable iff (!presetn) // R5
    warm_rst_n && link_err_flags[BIT_LAST_RETRY_A] && en0_reg[BIT_LAST_RETRY_B]
    |=> err_out0)
    else $error("last retry not routed through its twin enable bit");

  AST_CRC_OUT0: assert property (@(posedge pclk) disable iff (!presetn) // R14
    warm_rst_n && link_err_flags[BIT_INBOUND_CRC] && en0_reg[BIT_INBOUND_CRC]
    |=> err_out0)
    else $error("inbound crc error not routed to out 0");

  AST_ENABLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // R1
    wr && idx == ERR0_EN_INDEX && pstrb[1:0] == 2'h3
    |=> en0_reg == ($past(pwdata[15:0]) & ENABLE_WRITABLE))
    else $error("enable write to out 0 register not stored");

  AST_STICKY_WARM: assert property (@(posedge pclk) disable iff (!presetn) // R18
    !warm_rst_n && !wr |=> $stable(en0_reg) && $stable(en1_reg))
    else $error("warm reset disturbed a sticky enable register");

  // one cycle only: a clear or a warm reset may legally drop it after that
  AST_IRQ_ON_RISE: assert property (@(posedge pclk) disable iff (!presetn) // R1
    warm_rst_n && rise[IRQ_OUT0_RISE] && mask_reg[IRQ_OUT0_RISE]
    && !(wr && idx == IRQ_MASK_INDEX) |=> irq)
    else $error("interrupt missing after out 0 rise");

  // interrupt status bookkeeping
  AST_STAT_SET: assert property (@(posedge pclk) disable iff (!presetn) // R1
    warm_rst_n |=> (stat_reg & $past(rise)) == $past(rise))
    else $error("a rise did not set its status bit");

  AST_STAT_W1C: assert property (@(posedge pclk) disable iff (!presetn) // R1
    warm_rst_n && wr && idx == IRQ_STAT_INDEX && pstrb[0] && pwdata[0]
    && !rise[IRQ_OUT0_RISE] |=> !stat_reg[IRQ_OUT0_RISE])
    else $error("writing one did not clear status bit 0");

  AST_WARM_CLEARS: assert property (@(posedge pclk) disable iff (!presetn) // R18
    !warm_rst_n |=> !err_out0 && !err_out1
    && (stat_reg == IRQ_RESET) && (mask_reg == IRQ_RESET))
    else $error("warm reset left non-sticky state set");

  AST_EN1_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // R2
    wr && idx == ERR1_EN_INDEX && pstrb[1:0] == 2'h3
    |=> en1_reg == ($past(pwdata[15:0]) & ENABLE_WRITABLE))
    else $error("enable write to out 1 register not stored");

  // any enabled flag must reach its output, whatever its position
  AST_ANY_OUT0: assert property (@(posedge pclk) disable iff (!presetn) // R17
    warm_rst_n && |(link_err_flags & en0_reg[FLAG_W-1:0]) |=> err_out0)
    else $error("an enabled flag did not reach out 0");

  AST_ANY_OUT1: assert property (@(posedge pclk) disable iff (!presetn) // R17
    warm_rst_n && |(link_err_flags & en1_reg[FLAG_W-1:0]) |=> err_out1)
    else $error("an enabled flag did not reach out 1");

  AST_NO_FLAG_QUIET: assert property (@(posedge pclk) disable iff (!presetn) // R17
    link_err_flags == '0 |=> !err_out0 && !err_out1)
    else $error("an output is high with no flag set");

  // spot checks on single conditions, on both outputs
  AST_UNCORR_OUT1: assert property (@(posedge pclk) disable iff (!presetn) // R6
    warm_rst_n && link_err_flags[BIT_UNCORR_REMOTE] && en1_reg[BIT_UNCORR_REMOTE]
    |=> err_out1)
    else $error("uncorrectable remote error not routed to out 1");

  AST_HOTPLUG_OUT1: assert property (@(posedge pclk) disable iff (!presetn) // R10
    warm_rst_n && link_err_flags[BIT_HOTPLUG_BUS] && en1_reg[BIT_HOTPLUG_BUS]
    |=> err_out1)
    else $error("hot-plug bus error not routed to out 1");

  AST_ABORT_OUT0: assert property (@(posedge pclk) disable iff (!presetn) // R11
    warm_rst_n && link_err_flags[BIT_LINK_ABORT] && en0_reg[BIT_LINK_ABORT]
    |=> err_out0)
    else $error("inbound link abort not routed to out 0");

  AST_POISON_OUT0: assert property (@(posedge pclk) disable iff (!presetn) // R13
    warm_rst_n && link_err_flags[BIT_POISON_MEM_WRITE] && en0_reg[BIT_POISON_MEM_WRITE]
    |=> err_out0)
    else $error("poisoned memory write not routed to out 0");

  AST_ECC_OUT1: assert property (@(posedge pclk) disable iff (!presetn) // R16
    warm_rst_n && link_err_flags[BIT_INBOUND_UNCORR_ECC] && en1_reg[BIT_INBOUND_UNCORR_ECC]
    |=> err_out1)
    else $error("inbound uncorrectable ecc error not routed to out 1");

  COV_OUT0: cover property (@(posedge pclk) disable iff (!presetn)
    !err_out0 ##1 err_out0);
  COV_BOTH: cover property (@(posedge pclk) disable iff (!presetn)
    err_out0 && err_out1);
  COV_CLEAR_RACE: cover property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IRQ_STAT_INDEX && |rise);
  COV_WARM: cover property (@(posedge pclk) disable iff (!presetn)
    !warm_rst_n && en0_reg != '0);
  COV_LAST_RETRY_CROSS: cover property (@(posedge pclk) disable iff (!presetn)
    link_err_flags[BIT_LAST_RETRY_B] && en0_reg[BIT_LAST_RETRY_A]);

endmodule

`default_nettype wire

// ===== verification/link_err_source.sv
// behavioural model of the link error detection logic that feeds the flags
`timescale 1ns/1ps
`default_nettype none

module link_err_source (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bench control: wanted flag levels, slow adds one more cycle of latency
  input  wire logic [14:0] want,
  input  wire logic        slow,
  // flag levels toward the routing block
  output var  logic [14:0] link_err_flags
);
  logic [14:0] stage_reg;

  // ==========================================================
  // flags are registered levels, as the real detectors would present them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg      <= '0;
      link_err_flags <= '0;
    end else begin
      stage_reg      <= want;
      link_err_flags <= slow ? stage_reg : want;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the link error-signal routing block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import memlink_err_pkg::*;
  localparam logic [13:0] A0 = {ERR0_EN_INDEX, 2'b00};
  localparam logic [13:0] A1 = {ERR1_EN_INDEX, 2'b00};
  localparam logic [13:0] AS = {IRQ_STAT_INDEX, 2'b00};
  localparam logic [13:0] AM = {IRQ_MASK_INDEX, 2'b00};
  localparam logic [13:0] AF = {FLAG_VIEW_INDEX, 2'b00};

  logic        pclk, presetn, warm_rst_n, psel, penable, pwrite, pready, pslverr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [14:0] flags, want;
  logic        slow, err_out0, err_out1, irq, e;
  logic [15:0] e0, e1;
  integer      seed, fail_count, total_checks;

  memlink_error_signal_routing u_dut (.pclk(pclk), .presetn(presetn),
    .warm_rst_n(warm_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_err_flags(flags), .err_out0(err_out0),
    .err_out1(err_out1), .irq(irq));
  link_err_source u_src (.pclk(pclk), .presetn(presetn), .want(want), .slow(slow),
    .link_err_flags(flags));

  // ==========================================================
  // clock and hang guard
  always #20 pclk = ~pclk;
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count = fail_count + 1;
    close_out;
  end

  // ==========================================================
  // helpers
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; the leading edge keeps two transfers from colliding
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count = fail_count + 1;
      close_out;
    end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // bits 13 and 9 name the same condition, so either flag meets either enable
  function automatic logic route(input logic [15:0] en, input logic [14:0] f);
    return (|(en[14:0] & f)) | ((en[13] | en[9]) & (f[13] | f[9]));
  endfunction

  task automatic settle(input logic [14:0] f);
    want <= f;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic routes(input logic [15:0] a, input logic [15:0] b, input logic [14:0] f);
    apb(1'b1, A0, {16'h0, a});
    apb(1'b1, A1, {16'h0, b});
    settle(f);
    chk(err_out0, route(a, f), "out0");
    chk(err_out1, route(b, f), "out1");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    pclk = 0; presetn = 0; warm_rst_n = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; pstrb = 4'hf; want = '0; slow = 0; seed = 82;
    fail_count = 0; total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A0, 0); chk(r, 32'h0, "en0 reset");
    apb(1'b0, A1, 0); chk(r, 32'h0, "en1 reset");
    apb(1'b1, A0, 32'hffffffff); apb(1'b0, A0, 0); chk(r, 32'h7fff, "en0 rsvd");
    chk(e, 1'b0, "mapped no err");
    // lane 0 only: the upper enable byte must keep its old value
    pstrb <= 4'h1; apb(1'b1, A0, 32'h00005a5a); pstrb <= 4'hf;
    apb(1'b0, A0, 0); chk(r, 32'h7f5a, "en0 lane 0 only");
    apb(1'b1, A1, 32'h0000ffff); apb(1'b0, A1, 0); chk(r, 32'h7fff, "en1 rsvd");
    apb(1'b1, 14'h3fc, 32'h1); chk(e, 1'b1, "unmapped err");
    $display("test registers done");
    // each condition alone on out 0, then its out-1 enable against every other condition
    for (int b = 0; b < 15; b++) begin
      e0 = 16'h1 << b;
      routes(e0, 16'h0, 15'h1 << b);
      routes(16'h0, e0, ~(15'h1 << b));
    end
    routes(16'h2000, 16'h0, 15'h0200);
    routes(16'h0, 16'h0200, 15'h2000);
    $display("test per bit done");
    for (int i = 0; i < 24; i++) begin
      e0 = 16'($random(seed));
      // one output per condition; bits 13 and 9 count as one condition
      e1 = 16'($random(seed)) & ~e0 & ((e0[13] | e0[9]) ? 16'hddff : 16'hffff);
      slow = 1'($random(seed));
      routes(e0, e1, 15'($random(seed)));
    end
    slow = 0;
    $display("test random done");
    // warm reset drops outputs but keeps the sticky enables
    routes(16'h0010, 16'h0, 15'h0010);
    @(posedge pclk); warm_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk); chk(err_out0, 1'b0, "warm out0");
    @(posedge pclk); warm_rst_n <= 1'b1;
    apb(1'b0, A0, 0); chk(r, 32'h0010, "warm keeps en0");
    settle(15'h0010); chk(err_out0, 1'b1, "warm resume");
    $display("test warm reset done");
    // interrupt: raise, clear, mask
    routes(16'h0, 16'h0, 15'h0);
    apb(1'b1, AS, 32'h3); apb(1'b1, AM, 32'h1);
    routes(16'h0008, 16'h0, 15'h0008);
    chk(irq, 1'b1, "irq set");
    apb(1'b0, AF, 0); chk(r[16:0], 17'h10008, "flag view");
    apb(1'b0, AS, 0); chk(r, 32'h1, "status");
    settle(15'h0); apb(1'b1, AS, 32'h1); @(negedge pclk); chk(irq, 1'b0, "irq clr");
    apb(1'b1, AM, 32'h0); routes(16'h0008, 16'h0, 15'h0008);
    chk(irq, 1'b0, "irq masked");
    $display("test interrupt done");
    // power-good reset clears the enables
    @(posedge pclk); presetn <= 1'b0;
    repeat (2) @(posedge pclk); presetn <= 1'b1;
    apb(1'b0, A0, 0); chk(r, 32'h0, "pg clears en0");
    chk(err_out0, 1'b0, "pg quiets out0");
    $display("test power reset done");
    close_out;
  end
endmodule
`default_nettype wire
